/* core/nms_sequencer.sv */
// How it works
// - top bits 00 issue an opcode picked by the low six bits
// - opcode index maps through the table, index 8 gives 10 hex
// - zero-address state sends zeros for the column cycle count
// - first row address sent, advancing by page or block after each loop-back
// - first column is offset times sector-plus-parity, or both offsets in byte mode
// - third and later first-column uses in a flow send zero
// - second row state mirrors the first; second column is the low five bits of the second offset times sector-plus-parity
// - bit-flip states send a row address with the chosen bit inverted
// - spare column is sector-plus-parity times sectors per page plus offset
// - fixed row states send the starting rows with no loop increment
// - variable states send one byte each of the variable address word
// - wait states pause for the programmed timing count
// - data states move sector data then parity until page or counter end
// - busy state stalls until ready/busy goes high
// - end state finishes the command and drops chip select
// - spare states move the spare length plus one bytes until the counter runs out
// - single status reads once; multi status polls until ready; both report
// - blank states move a whole page using the compare pattern
// - chip select steps up or down by exactly one
// - check-ready polls ready without reporting a result
// - link ends a flow keeping chip select active; chains end with end
// - call codes jump to a subroutine named by the next byte; return resumes
// - loop-back goes back by its value while any bytes remain
module nms_sequencer (
	// clock and reset
	input wire logic MCLK_IN,
	input wire logic ARST_N_IN,
	// command start and microcode fetch
	input wire logic START_IN,
	input wire logic [7:0] FLOW_BASE_IN,
	output logic [7:0] FETCH_ADDR_OUT,
	output logic FETCH_PROG_OUT,
	input wire logic [7:0] FETCH_DATA_IN,
	input wire nms_pkg::nms_cmd_t CMD_IN,
	input wire nms_pkg::nms_cfg_t CFG_IN,
	input wire logic [63:0] PROG_OPCODES_IN,
	input wire logic [7:0] BLANK_PATTERN_IN,
	// data stream from firmware side
	input wire logic WDATA_VALID_IN,
	output logic WDATA_READY_OUT,
	input wire logic [7:0] WDATA_IN,
	// flash side
	output nms_pkg::nms_flash_t FLASH_OUT,
	input wire logic FLASH_READY_IN,
	input wire logic FLASH_STROBE_DONE_IN,
	input wire logic [7:0] FLASH_RDATA_IN,
	output logic FLASH_CE_N_OUT,
	output logic [2:0] FLASH_CE_SEL_OUT,
	// status
	output logic BUSY_OUT,
	output logic DONE_OUT,
	output logic LINKED_OUT,
	output logic STATUS_VALID_OUT,
	output logic STATUS_FAIL_OUT,
	output logic BLANK_FAIL_OUT,
	output logic [7:0] RDATA_OUT,
	output logic RDATA_VALID_OUT
);
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH, S_DECODE, S_CALL, S_ADDR, S_WAIT, S_XFER, S_POLL, S_STAT
	} nms_state_t;

	typedef struct packed {
		nms_state_t st;
		logic [7:0] pc;
		logic [7:0] ret_pc;
		logic in_sub;
		logic prog;
		logic [7:0] code;
		logic [31:0] addr;
		logic [2:0] left;
		logic [31:0] cnt;
		logic [1:0] col1_uses;
		logic [31:0] row1;
		logic [31:0] row2;
		logic [31:0] remain;
		logic ce_n;
		logic [2:0] ce_sel;
		nms_pkg::nms_flash_t fl;
		logic done;
		logic linked;
		logic stat_v;
		logic stat_fail;
		logic blank_fail;
		logic [7:0] rdata;
		logic rdata_v;
	} nms_reg_t;

	nms_reg_t q;
	nms_reg_t d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [7:0] op_byte;
	logic fifo_valid;
	logic fifo_ready;
	logic [7:0] fifo_data;
	logic [31:0] unit;
	logic [31:0] page_bytes;
	logic wr_stream;

	// reset release through two flops
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////
	// helpers

	nms_opcode_rom u_rom (
		.index_in(q.code[5:0]),
		.prog_bytes_in(PROG_OPCODES_IN),
		.opcode_out(op_byte)
	);

	nms_fifo #(.WIDTH(nms_pkg::FIFO_WIDTH), .DEPTH(nms_pkg::FIFO_DEPTH)) u_fifo (
		.clk_in(MCLK_IN),
		.rst_n_in(rst_n),
		.in_valid_in(WDATA_VALID_IN),
		.in_ready_out(WDATA_READY_OUT),
		.in_data_in(WDATA_IN),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_ready),
		.out_data_out(fifo_data)
	);

	// sector plus parity, and one page of it
	assign unit = 32'(nms_pkg::SECTOR_BYTES) + 32'(CFG_IN.ecc_parity);
	assign page_bytes = unit * 32'(CFG_IN.sec_per_page);

	// column for a sector offset
	function automatic logic [31:0] col_of(input logic [4:0] off, input logic [31:0] u);
		col_of = u * 32'(off);
	endfunction : col_of

	// write stream: a byte is popped as it is put on the bus, never after the last strobe
	assign wr_stream = q.st == S_XFER && (q.code[4:0] == nms_pkg::C_WDATA || q.code[4:0] == nms_pkg::C_WSPARE);
	assign fifo_ready = wr_stream && (q.fl.act == nms_pkg::NMS_ACT_IDLE || (FLASH_STROBE_DONE_IN && q.cnt > 32'h1));

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.stat_v = 1'b0;
		d.rdata_v = 1'b0;
		case (q.st)
			S_IDLE: begin
				d.fl.act = nms_pkg::NMS_ACT_IDLE;
				if (START_IN) begin
					d.pc = FLOW_BASE_IN;
					d.prog = 1'b0;
					d.in_sub = 1'b0;
					d.col1_uses = 2'h0;
					d.row1 = CMD_IN.row1;
					d.row2 = CMD_IN.row2;
					d.remain = 32'(CMD_IN.sectors) * unit;
					d.ce_n = 1'b0;
					d.linked = 1'b0;
					d.st = S_FETCH;
				end
			end
			S_FETCH: begin
				d.fl.act = nms_pkg::NMS_ACT_IDLE;
				d.code = FETCH_DATA_IN;
				d.st = S_DECODE;
			end
			S_DECODE: begin
				d.pc = q.pc + 8'h01;
				d.st = S_FETCH;
				if (q.code[7:6] == nms_pkg::MC_OPCODE) begin
					d.fl.act = nms_pkg::NMS_ACT_CMD;
					d.fl.data = op_byte;
				end else if (q.code[7:6] == nms_pkg::MC_GOBACK) begin
					if (q.remain != 32'h0) begin
						d.pc = q.pc - 8'(q.code[5:0]);
						d.row1 = q.row1 + (CMD_IN.step_block ? 32'(CFG_IN.pages_per_block) : 32'h1);
						d.row2 = q.row2 + (CMD_IN.step_block ? 32'(CFG_IN.pages_per_block) : 32'h1);
					end
				end else if (q.code[7:6] == nms_pkg::MC_CALL) begin
					d.ret_pc = q.pc + 8'h02;
					d.prog = q.code[5];
					d.pc = q.pc + 8'h01;
					d.st = S_CALL;
				end else if (q.code[7:5] == nms_pkg::MC_ADDR && q.code[4:0] <= nms_pkg::A_VAR4) begin
					d.st = S_ADDR;
					d.left = CMD_IN.row_cyc;
					case (q.code[4:0])
						nms_pkg::A_ZERO: begin
							d.addr = 32'h0;
							d.left = CMD_IN.col_cyc;
						end
						nms_pkg::A_ROW1: d.addr = q.row1;
						nms_pkg::A_COL1: begin
							d.left = CMD_IN.col_cyc;
							d.col1_uses = (q.col1_uses == 2'h3) ? 2'h3 : q.col1_uses + 2'h1;
							if (q.col1_uses >= 2'h2) begin
								d.addr = 32'h0;
							end else if (CMD_IN.byte_mode) begin
								d.addr = {16'h0, CMD_IN.sec_off2, 3'h0, CMD_IN.sec_off1};
							end else begin
								d.addr = col_of(CMD_IN.sec_off1, unit);
							end
						end
						nms_pkg::A_ROW2: d.addr = q.row2;
						nms_pkg::A_COL2: begin
							d.left = CMD_IN.col_cyc;
							d.addr = col_of(CMD_IN.sec_off2[4:0], unit);
						end
						nms_pkg::A_FLIP1: d.addr = q.row1 ^ (32'h1 << CFG_IN.flip_bit);
						nms_pkg::A_FLIP2: d.addr = q.row2 ^ (32'h1 << CFG_IN.flip_bit);
						nms_pkg::A_SPARE: begin
							d.left = CMD_IN.col_cyc;
							d.addr = page_bytes + 32'(CMD_IN.sec_off1);
						end
						nms_pkg::A_FIX1: d.addr = CMD_IN.row1;
						nms_pkg::A_FIX2: d.addr = CMD_IN.row2;
						default: begin
							d.left = 3'h1;
							d.addr = CFG_IN.var_addr >> {q.code[1:0] - 2'h2, 3'h0};
						end
					endcase
				end else if (q.code[7:5] == nms_pkg::MC_CTRL) begin
					case (q.code[4:0])
						nms_pkg::C_WAIT1, 5'h01, 5'h02, nms_pkg::C_WAIT4: begin
							d.cnt = CFG_IN.wait_cyc;
							d.st = S_WAIT;
						end
						nms_pkg::C_WDATA, nms_pkg::C_RDATA: begin
							d.cnt = (q.remain < page_bytes) ? q.remain : page_bytes;
							d.st = S_XFER;
							d.fl.act = q.code[0] ? nms_pkg::NMS_ACT_RD : nms_pkg::NMS_ACT_IDLE; // writes load first
						end
						nms_pkg::C_WSPARE, nms_pkg::C_RSPARE: begin
							d.cnt = 32'(CMD_IN.spare_len) + 32'h1;
							d.st = S_XFER;
							d.fl.act = q.code[0] ? nms_pkg::NMS_ACT_RD : nms_pkg::NMS_ACT_IDLE;
						end
						nms_pkg::C_BLANKW, nms_pkg::C_BLANKR: begin
							d.cnt = page_bytes;
							d.st = S_XFER;
							d.fl.act = q.code[0] ? nms_pkg::NMS_ACT_RD : nms_pkg::NMS_ACT_WR;
							d.fl.data = BLANK_PATTERN_IN;
						end
						nms_pkg::C_BUSY, nms_pkg::C_CHKRDY, nms_pkg::C_STATN: d.st = S_POLL;
						nms_pkg::C_STAT1: begin
							d.fl.act = nms_pkg::NMS_ACT_RD;
							d.st = S_STAT;
						end
						nms_pkg::C_END: begin
							d.ce_n = 1'b1;
							d.done = 1'b1;
							d.st = S_IDLE;
						end
						nms_pkg::C_LINK: begin
							d.linked = 1'b1;
							d.done = 1'b1;
							d.st = S_IDLE;
						end
						nms_pkg::C_CEINC: d.ce_sel = q.ce_sel + 3'h1;
						nms_pkg::C_CEDEC: d.ce_sel = q.ce_sel - 3'h1;
						nms_pkg::C_RET: begin
							if (q.in_sub) begin
								d.pc = q.ret_pc;
								d.prog = 1'b0;
								d.in_sub = 1'b0;
							end
						end
						default: d.fl.act = nms_pkg::NMS_ACT_IDLE;
					endcase
				end else begin
					d.fl.act = nms_pkg::NMS_ACT_IDLE;
				end
			end
			S_CALL: begin
				d.pc = FETCH_DATA_IN;
				d.in_sub = 1'b1;
				d.st = S_FETCH;
			end
			S_ADDR: begin
				d.fl.act = nms_pkg::NMS_ACT_ADDR;
				d.fl.data = q.addr[7:0];
				d.addr = q.addr >> 8;
				d.left = q.left - 3'h1;
				if (q.left <= 3'h1) begin
					d.st = S_FETCH;
				end
			end
			S_WAIT: begin
				d.fl.act = nms_pkg::NMS_ACT_IDLE;
				d.cnt = q.cnt - 32'h1;
				if (q.cnt <= 32'h1) begin
					d.st = S_FETCH;
				end
			end
			S_XFER: begin
				if (wr_stream) begin
					if (q.fl.act == nms_pkg::NMS_ACT_IDLE) begin
						if (fifo_valid) begin
							d.fl.act = nms_pkg::NMS_ACT_WR;
							d.fl.data = fifo_data;
						end
					end else if (FLASH_STROBE_DONE_IN) begin
						d.cnt = q.cnt - 32'h1;
						if (q.code[4:0] == nms_pkg::C_WDATA) begin
							d.remain = (q.remain == 32'h0) ? 32'h0 : q.remain - 32'h1;
						end
						if (q.cnt <= 32'h1) begin
							d.st = S_FETCH;
							d.fl.act = nms_pkg::NMS_ACT_IDLE;
						end else if (fifo_valid) begin
							d.fl.data = fifo_data;
						end else begin
							d.fl.act = nms_pkg::NMS_ACT_IDLE;
						end
					end
				end else if (FLASH_STROBE_DONE_IN) begin
					if (q.fl.act == nms_pkg::NMS_ACT_RD) begin
						d.rdata = FLASH_RDATA_IN;
						d.rdata_v = 1'b1;
						if (q.code[4:0] == nms_pkg::C_BLANKR && FLASH_RDATA_IN != BLANK_PATTERN_IN) begin
							d.blank_fail = 1'b1;
						end
					end
					d.cnt = q.cnt - 32'h1;
					if (q.code[4:0] == nms_pkg::C_WDATA || q.code[4:0] == nms_pkg::C_RDATA) begin
						d.remain = (q.remain == 32'h0) ? 32'h0 : q.remain - 32'h1;
					end
					if (q.cnt <= 32'h1) begin
						d.st = S_FETCH;
						d.fl.act = nms_pkg::NMS_ACT_IDLE;
					end
				end
			end
			S_POLL: begin
				d.fl.act = nms_pkg::NMS_ACT_IDLE;
				if (FLASH_READY_IN) begin
					d.st = S_FETCH;
					if (q.code[4:0] == nms_pkg::C_STATN) begin
						d.fl.act = nms_pkg::NMS_ACT_RD;
						d.st = S_STAT;
					end
				end
			end
			S_STAT: begin
				if (FLASH_STROBE_DONE_IN) begin
					d.fl.act = nms_pkg::NMS_ACT_IDLE;
					d.stat_v = 1'b1;
					d.stat_fail = |(FLASH_RDATA_IN & nms_pkg::STATUS_PASS_MASK[7:0]);
					d.st = S_FETCH;
				end
			end
			default: d.st = S_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.pc <= nms_pkg::PC_RST;
			q.ce_n <= 1'b1;
			q.ce_sel <= nms_pkg::CE_RST;
			q.st <= S_IDLE;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign FETCH_ADDR_OUT = q.pc;
	assign FETCH_PROG_OUT = q.prog;
	assign FLASH_OUT = q.fl;
	assign FLASH_CE_N_OUT = q.ce_n;
	assign FLASH_CE_SEL_OUT = q.ce_sel;
	assign BUSY_OUT = q.st != S_IDLE;
	assign DONE_OUT = q.done;
	assign LINKED_OUT = q.linked;
	assign STATUS_VALID_OUT = q.stat_v;
	assign STATUS_FAIL_OUT = q.stat_fail;
	assign BLANK_FAIL_OUT = q.blank_fail;
	assign RDATA_OUT = q.rdata;
	assign RDATA_VALID_OUT = q.rdata_v;

	////////////////////////////////////////////////////////////////
	// checks
	chk_opcode_issue: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code[7:6] == 2'h0 |=> FLASH_OUT.act == nms_pkg::NMS_ACT_CMD)
		else $error("opcode not issued");
	chk_opcode_map: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code == nms_pkg::OP_INDEX_EXAMPLE |=> FLASH_OUT.data == nms_pkg::OP_VALUE_EXAMPLE)
		else $error("opcode index 8 wrong");
	chk_zero_addr: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code == 8'h40 && CMD_IN.col_cyc != 3'h0 |=> ##1 FLASH_OUT.data == 8'h00)
		else $error("zero address not zero");
	chk_col1_zero: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code == 8'h42 && q.col1_uses >= 2'h2 |=> q.addr == 32'h0)
		else $error("late column not zero");
	chk_wait_len: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code == 8'h60 && CFG_IN.wait_cyc == 32'h4 |=> q.st == S_WAIT [*4] ##1 q.st == S_FETCH)
		else $error("wait length wrong");
	chk_busy_stall: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_POLL && !FLASH_READY_IN |=> q.st == S_POLL)
		else $error("busy did not stall");
	chk_end_ce: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code == 8'h67 |=> FLASH_CE_N_OUT && DONE_OUT && !BUSY_OUT)
		else $error("end did not release");
	chk_ce_step: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code == 8'h6e |=> FLASH_CE_SEL_OUT == $past(FLASH_CE_SEL_OUT) + 3'h1)
		else $error("ce step wrong");
	chk_link_ce: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code == 8'h73 |=> !FLASH_CE_N_OUT && LINKED_OUT)
		else $error("link dropped ce");
	chk_goback_pc: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
		q.st == S_DECODE && q.code[7:6] == 2'h3 && q.remain != 32'h0
		|=> FETCH_ADDR_OUT == $past(q.pc) - 8'($past(q.code[5:0])))
		else $error("goback target wrong");
endmodule : nms_sequencer

/* core/nms_pkg.sv */
package nms_pkg;
	// microcode classes
	localparam logic [1:0] MC_OPCODE = 2'h0;
	localparam logic [1:0] MC_CALL = 2'h2;
	localparam logic [1:0] MC_GOBACK = 2'h3;
	localparam logic [2:0] MC_ADDR = 3'h2;
	localparam logic [2:0] MC_CTRL = 3'h3;
	// address sub-codes
	localparam logic [4:0] A_ZERO = 5'h00;
	localparam logic [4:0] A_ROW1 = 5'h01;
	localparam logic [4:0] A_COL1 = 5'h02;
	localparam logic [4:0] A_ROW2 = 5'h03;
	localparam logic [4:0] A_COL2 = 5'h04;
	localparam logic [4:0] A_FLIP1 = 5'h05;
	localparam logic [4:0] A_FLIP2 = 5'h06;
	localparam logic [4:0] A_SPARE = 5'h07;
	localparam logic [4:0] A_FIX1 = 5'h08;
	localparam logic [4:0] A_FIX2 = 5'h09;
	localparam logic [4:0] A_VAR1 = 5'h0a;
	localparam logic [4:0] A_VAR4 = 5'h0d;
	// control sub-codes
	localparam logic [4:0] C_WAIT1 = 5'h00;
	localparam logic [4:0] C_WAIT4 = 5'h03;
	localparam logic [4:0] C_WDATA = 5'h04;
	localparam logic [4:0] C_RDATA = 5'h05;
	localparam logic [4:0] C_BUSY = 5'h06;
	localparam logic [4:0] C_END = 5'h07;
	localparam logic [4:0] C_WSPARE = 5'h08;
	localparam logic [4:0] C_RSPARE = 5'h09;
	localparam logic [4:0] C_STAT1 = 5'h0a;
	localparam logic [4:0] C_STATN = 5'h0b;
	localparam logic [4:0] C_BLANKW = 5'h0c;
	localparam logic [4:0] C_BLANKR = 5'h0d;
	localparam logic [4:0] C_CEINC = 5'h0e;
	localparam logic [4:0] C_CEDEC = 5'h0f;
	localparam logic [4:0] C_RET = 5'h11;
	localparam logic [4:0] C_CHKRDY = 5'h12;
	localparam logic [4:0] C_LINK = 5'h13;
	// sizes and reset values
	localparam int SECTOR_BYTES = 512;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 8;
	localparam logic [7:0] PC_RST = 8'h00;
	localparam logic [2:0] CE_RST = 3'h0;
	localparam logic [7:0] OP_INDEX_EXAMPLE = 8'h08;
	localparam logic [7:0] OP_VALUE_EXAMPLE = 8'h10;
	localparam logic [15:0] STATUS_PASS_MASK = 16'h0001;
	localparam logic [7:0] FLIP_EXAMPLE = 8'h80;

	// flash-side action presented to the pin layer
	typedef enum logic [2:0] {
		NMS_ACT_IDLE,
		NMS_ACT_CMD,
		NMS_ACT_ADDR,
		NMS_ACT_WR,
		NMS_ACT_RD
	} nms_act_t;

	typedef struct packed {
		nms_act_t act;
		logic [7:0] data;
	} nms_flash_t;

	// command table entry written by firmware
	typedef struct packed {
		logic [31:0] row1;
		logic [31:0] row2;
		logic [4:0] sec_off1;
		logic [7:0] sec_off2;
		logic [2:0] row_cyc;
		logic [2:0] col_cyc;
		logic byte_mode;
		logic step_block;
		logic [15:0] sectors;
		logic [5:0] spare_len;
	} nms_cmd_t;

	typedef struct packed {
		logic [7:0] ecc_parity;
		logic [4:0] sec_per_page;
		logic [7:0] pages_per_block;
		logic [4:0] flip_bit;
		logic [31:0] var_addr;
		logic [31:0] wait_cyc;
	} nms_cfg_t;
endpackage : nms_pkg

/* core/nms_opcode_rom.sv */
module nms_opcode_rom (
	// index in, opcode out
	input wire logic [5:0] index_in,
	input wire logic [63:0] prog_bytes_in,
	output logic [7:0] opcode_out
);
	logic [7:0] rom [0:54];

	// fixed opcode table
	assign rom = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h09, 8'h0d, 8'h10, 8'h11, 8'h15, 8'h1a,
		8'h30, 8'h31, 8'h32, 8'h35, 8'h3a, 8'h3c, 8'h3f, 8'h50, 8'h55, 8'h5c, 8'h5d, 8'h60,
		8'h69, 8'h70, 8'h71, 8'h78, 8'h7b, 8'h80, 8'h81, 8'h85, 8'h8a, 8'h8b, 8'h8c, 8'h90,
		8'ha2, 8'hc0, 8'hc5, 8'hd0, 8'hd1, 8'hda, 8'hdf, 8'he0, 8'he1, 8'he2, 8'hec, 8'hed,
		8'hee, 8'hef, 8'hf1, 8'hf2, 8'hfa, 8'hfc, 8'hff};

	// programmable slots follow the fixed ones
	always_comb begin
		if (index_in < 6'd55) begin
			opcode_out = rom[index_in];
		end else if (index_in == 6'd63) begin
			opcode_out = 8'h00;
		end else begin
			opcode_out = prog_bytes_in[(index_in - 6'd55) * 8 +: 8];
		end
	end
endmodule : nms_opcode_rom

/* core/nms_fifo.sv */
module nms_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	// honest full and empty
	assign in_ready_out = (wr_q - rd_q) != (AW + 1)'(DEPTH);
	assign out_valid_out = wr_q != rd_q;
	assign out_data_out = mem[rd_q[AW-1:0]];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	// pointers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW + 1)'(push);
			rd_q <= rd_q + (AW + 1)'(pop);
		end
	end

	// storage
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data_in;
		end
	end
endmodule : nms_fifo

/* verification/nms_flash_model.sv */
module nms_flash_model (
	// clock and flash side
	input wire logic clk_in,
	input wire nms_pkg::nms_flash_t flash_in,
	output logic ready_out,
	output logic done_out,
	output logic [7:0] rdata_out,
	// bench controls and counts
	input wire logic slow_in,
	input wire logic [7:0] status_in,
	output int wr_cnt_out,
	output int rd_cnt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ph_q = 1'b0;
	logic xfer;
	int busy_q = 0;
	int wr_q = 0;
	int rd_q = 0;
	////////////////////////////////////////////////////////////////
	// strobe taken each cycle, or every other cycle when slow
	assign xfer = flash_in.act inside {nms_pkg::NMS_ACT_WR, nms_pkg::NMS_ACT_RD};
	assign done_out = xfer && (!slow_in || ph_q);
	// released bus shows the inverse, never the last byte
	assign rdata_out = done_out ? status_in : ~status_in;
	assign ready_out = (busy_q == 0);
	assign wr_cnt_out = wr_q;
	assign rd_cnt_out = rd_q;
	////////////////////////////////////////////////////////////////
	// busy window after the d0 opcode, strobe counts
	always @(posedge clk_in) begin
		ph_q <= ~ph_q;
		if (flash_in.act == nms_pkg::NMS_ACT_CMD && flash_in.data == 8'hd0) busy_q <= 20;
		else if (busy_q != 0) busy_q <= busy_q - 1;
		if (done_out && flash_in.act == nms_pkg::NMS_ACT_WR) wr_q <= wr_q + 1;
		if (done_out && flash_in.act == nms_pkg::NMS_ACT_RD) rd_q <= rd_q + 1;
	end
endmodule : nms_flash_model

/* verification/test_nms_sequencer.sv */
module test_nms_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, arst_n = 1'b0, start = 1'b0, wv = 1'b0, slow = 1'b0, rdy_s = 1'b0;
	logic [7:0] mem [256];
	logic [7:0] wd = 8'h00, stat = 8'h00, fa, fd, rdat, ro;
	logic fp, fr, fdone, wr, cen, busy, done, lnk, sv, sf, bf, rv;
	logic [2:0] csel;
	nms_pkg::nms_cmd_t cmd;
	nms_pkg::nms_cfg_t cfg;
	nms_pkg::nms_flash_t fl;
	int errors = 0, num_checks = 0, sent = 0, limit = 0, stc = 0, wn, rn, w0, r0, s0;
	logic [7:0] logq[$], expq[$];
	////////////////////////////////////////////////////////////////
	// clock, microcode table, design and far side
	always #5 clk = ~clk;
	assign fd = mem[fa];
	nms_sequencer dut_u (.MCLK_IN(clk), .ARST_N_IN(arst_n), .START_IN(start), .FLOW_BASE_IN(8'h00),
		.FETCH_ADDR_OUT(fa), .FETCH_PROG_OUT(fp), .FETCH_DATA_IN(fd), .CMD_IN(cmd), .CFG_IN(cfg),
		.PROG_OPCODES_IN(64'ha500_0000_0000_005a), .BLANK_PATTERN_IN(8'hff), .WDATA_VALID_IN(wv),
		.WDATA_READY_OUT(wr), .WDATA_IN(wd), .FLASH_OUT(fl), .FLASH_READY_IN(fr),
		.FLASH_STROBE_DONE_IN(fdone), .FLASH_RDATA_IN(rdat), .FLASH_CE_N_OUT(cen),
		.FLASH_CE_SEL_OUT(csel), .BUSY_OUT(busy), .DONE_OUT(done), .LINKED_OUT(lnk),
		.STATUS_VALID_OUT(sv), .STATUS_FAIL_OUT(sf), .BLANK_FAIL_OUT(bf), .RDATA_OUT(ro),
		.RDATA_VALID_OUT(rv));
	nms_flash_model far_u (.clk_in(clk), .flash_in(fl), .ready_out(fr), .done_out(fdone),
		.rdata_out(rdat), .slow_in(slow), .status_in(stat), .wr_cnt_out(wn), .rd_cnt_out(rn));
	////////////////////////////////////////////////////////////////
	// ready sampled mid-cycle for the write stream
	always @(negedge clk) rdy_s = wr;
	// log command and address bytes, status pulses, write stream
	always @(posedge clk) begin
		if (fl.act inside {nms_pkg::NMS_ACT_CMD, nms_pkg::NMS_ACT_ADDR}) logq.push_back(fl.data);
		if (fl.act == nms_pkg::NMS_ACT_CMD && fl.data == 8'h70 && fr !== 1'b1) chk(0, 1);
		if (sv === 1'b1) stc <= stc + 1;
		if (wv && rdy_s) begin
			wd <= wd + 8'h01;
			sent <= sent + 1;
			if (sent + 1 >= limit) wv <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// load a flow, start it, wait for done under a bound
	task automatic run(input logic [7:0] q[$]);
		int n;
		n = 0;
		@(posedge clk);
		foreach (q[i]) mem[i] <= q[i];
		logq.delete();
		w0 = wn;
		r0 = rn;
		s0 = stc;
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		while (done !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 20000) begin
				errors++;
				tally_and_finish();
			end
		end
	endtask : run
	task automatic cmp_log();
		chk(logq.size(), expq.size());
		foreach (expq[i]) if (i < logq.size()) chk(logq[i], expq[i]);
	endtask : cmp_log
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		cmd = '{32'h00a1b2c3, 32'h00d4e5f6, 5'h01, 8'h02, 3'h3, 3'h2, 1'b0, 1'b0, 16'h0001, 6'h03};
		cfg = '{8'h03, 5'h04, 8'h40, 5'h07, 32'h44332211, 32'h00000004};
		foreach (mem[i]) mem[i] = 8'h67;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(cen, 1);
		chk(csel, 0);
		// opcodes and every address state except spare
		expq = '{8'h00, 8'h10, 8'h85, 8'hff, 8'h5a, 8'ha5, 8'hc3, 8'hb2, 8'ha1, 8'h03, 8'h02, 8'hf6, 8'he5,
			8'hd4, 8'h06, 8'h04, 8'h43, 8'hb2, 8'ha1, 8'h76, 8'he5, 8'hd4, 8'hc3, 8'hb2, 8'ha1, 8'hf6, 8'he5,
			8'hd4, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00};
		run('{8'h00, 8'h08, 8'h1f, 8'h36, 8'h37, 8'h3e, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h48,
			8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h40, 8'h67});
		cmp_log();
		// byte mode column used three times
		@(posedge clk) cmd.byte_mode <= 1'b1;
		expq = '{8'h01, 8'h02, 8'hc3, 8'hb2, 8'ha1, 8'h01, 8'h02, 8'hc3, 8'hb2, 8'ha1, 8'h00, 8'h00};
		run('{8'h42, 8'h41, 8'h42, 8'h41, 8'h42, 8'h67});
		cmp_log();
		// reserved codes skipped, spare column
		@(posedge clk) cmd.byte_mode <= 1'b0;
		cmd.sec_off1 <= 5'h00;
		expq = '{8'h0c, 8'h08};
		run('{8'h7f, 8'h5f, 8'h47, 8'h67});
		cmp_log();
		// fill the write buffer until refused, then drain to a slow flash
		@(posedge clk) limit <= 515;
		wv <= 1'b1;
		slow <= 1'b1;
		repeat (25) @(posedge clk);
		#1;
		chk(sent, 16);
		chk(wr, 0);
		expq = '{8'h80};
		run('{8'h1d, 8'h64, 8'h67});
		cmp_log();
		chk(wn - w0, 515);
		chk(sent, 515);
		// loop-back over two pages of reads
		@(posedge clk) slow <= 1'b0;
		cmd.sectors <= 16'h0008;
		expq = '{8'h10, 8'hc3, 8'hb2, 8'ha1, 8'hc4, 8'hb2, 8'ha1};
		run('{8'h08, 8'h41, 8'h65, 8'hc2, 8'h67});
		cmp_log();
		chk(rn - r0, 4120);
		// wait, busy stall, chip-select steps, link
		expq = '{8'hd0, 8'h70};
		run('{8'h27, 8'h60, 8'h66, 8'h19, 8'h6e, 8'h6e, 8'h6f, 8'h72, 8'h73});
		cmp_log();
		chk(csel, 1);
		chk(cen, 0);
		chk(lnk, 1);
		// linked flow finished by end: spare read and single status
		@(posedge clk) stat <= 8'h01;
		run('{8'h69, 8'h6a, 8'h67});
		chk(rn - r0, 5);
		chk(stc - s0, 1);
		chk(sf, 1);
		chk(cen, 1);
		chk(lnk, 0);
		// polled status passing
		@(posedge clk) stat <= 8'h00;
		run('{8'h6b, 8'h67});
		chk(stc - s0, 1);
		chk(sf, 0);
		tally_and_finish();
	end
endmodule : test_nms_sequencer
